// File: rtl/cps_consts.vh
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH

// clock rates
`define CPS_CORE_HZ 100000000
`define CPS_CONV_HZ 5000000
`define CPS_CONV_DIV (`CPS_CORE_HZ / `CPS_CONV_HZ)
`define CPS_CONV_DIV_W 5
`define CPS_SLOW_TICKS_PER_MS 32

// channel geometry
`define CPS_NUM_CH 4
`define CPS_CH_NONE 3'h4
`define CPS_RES_W 16
`define CPS_SUM_W 21
`define CPS_CODE_W 3

// code decode limits
`define CPS_OSR_BASE 11'h010
`define CPS_OSR_CODE_MAX 3'h6
`define CPS_AVG_CODE_MAX 3'h5
`define CPS_ALPHA_CODE_MAX 3'h6

// scan interval
`define CPS_SCAN_CODE_W 5
`define CPS_SCAN_CODE_DEFAULT 5'h17
`define CPS_SCAN_CNT_W 20

// result memory word: {level, diff, raw}
`define CPS_MEM_W 34
`define CPS_MEM_RAW_LSB 0
`define CPS_MEM_DIFF_LSB 16
`define CPS_MEM_LVL_LSB 32

`endif

// File: rtl/cps_result_mem.v
`include "cps_consts.vh"

module cps_result_mem (
    // clock and reset
    input wire clk,
    input wire rstN,
    // write port
    input wire wrEn,
    input wire [1:0] wrAddr,
    input wire [`CPS_MEM_W-1:0] wrData,
    // read port
    input wire [1:0] rdAddr,
    output reg [`CPS_MEM_W-1:0] rdData
);

    reg [`CPS_MEM_W-1:0] mem [0:`CPS_NUM_CH-1];
    integer i;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            for (i = 0; i < `CPS_NUM_CH; i = i + 1) begin
                mem[i] <= {`CPS_MEM_W{1'b0}};
            end
            rdData <= {`CPS_MEM_W{1'b0}};
        end else begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end

endmodule // cps_result_mem

// File: rtl/cps_scan_timer.v
`include "cps_consts.vh"

module cps_scan_timer #(
    parameter TICKS_PER_MS = `CPS_SLOW_TICKS_PER_MS
) (
    // clock and reset
    input wire clk,
    input wire rstN,
    // slow oscillator pin
    input wire slowClkPin,
    // control
    input wire run,
    input wire ready,
    input wire [`CPS_SCAN_CODE_W-1:0] intervalCode,
    output reg scanStart
);

    reg slowS1Q, slowS2Q, slowS3Q;
    reg [`CPS_SCAN_CNT_W-1:0] cntQ;
    wire slowEdge = slowS2Q & ~slowS3Q;
    wire [31:0] prod;
    wire [`CPS_SCAN_CNT_W-1:0] target;

    // idle time in ms for each interval code
    function [9:0] codeMs;
        input [4:0] c;
        begin
            case (c)
                5'h00: codeMs = 10'd0;
                5'h01: codeMs = 10'd2;
                5'h02: codeMs = 10'd4;
                5'h03: codeMs = 10'd6;
                5'h04: codeMs = 10'd8;
                5'h05: codeMs = 10'd10;
                5'h06: codeMs = 10'd14;
                5'h07: codeMs = 10'd18;
                5'h08: codeMs = 10'd22;
                5'h09: codeMs = 10'd26;
                5'h0a: codeMs = 10'd30;
                5'h0b: codeMs = 10'd34;
                5'h0c: codeMs = 10'd38;
                5'h0d: codeMs = 10'd42;
                5'h0e: codeMs = 10'd46;
                5'h0f: codeMs = 10'd50;
                5'h10: codeMs = 10'd56;
                5'h11: codeMs = 10'd62;
                5'h12: codeMs = 10'd68;
                5'h13: codeMs = 10'd74;
                5'h14: codeMs = 10'd80;
                5'h15: codeMs = 10'd90;
                5'h16: codeMs = 10'd100;
                5'h17: codeMs = 10'd200;
                5'h18: codeMs = 10'd300;
                5'h19: codeMs = 10'd400;
                5'h1a: codeMs = 10'd600;
                5'h1b: codeMs = 10'd800;
                default: codeMs = 10'd1000;
            endcase
        end
    endfunction

    assign prod = codeMs(intervalCode) * TICKS_PER_MS;
    assign target = prod[`CPS_SCAN_CNT_W-1:0];

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            slowS1Q <= 1'b0;
            slowS2Q <= 1'b0;
            slowS3Q <= 1'b0;
            cntQ <= {`CPS_SCAN_CNT_W{1'b0}};
            scanStart <= 1'b0;
        end else begin
            slowS1Q <= slowClkPin;
            slowS2Q <= slowS1Q;
            slowS3Q <= slowS2Q;
            // idle time counted in slow ticks only between scans
            if (!run || !ready || scanStart) begin
                cntQ <= {`CPS_SCAN_CNT_W{1'b0}};
            end else if (slowEdge && !(&cntQ)) begin
                cntQ <= cntQ + 1'b1;
            end
            scanStart <= run && ready && !scanStart && (cntQ >= target);
        end
    end

endmodule // cps_scan_timer

// File: rtl/cps_scan_seq.v
// Summary of operation
// - empty channel mask means sleep mode
// - any mask bit set enters scan mode
// - each enabled channel measured once per period
// - doze without proximity uses slow period
// - doze proximity switches to fast period
// - slow clock always runs, times interval
// - conversion clock runs only while scanning
// - every conversion yields sixteen bit result
// - output only after averaging selected count
// - per channel oversampling ratio selectable
// - per channel full scale selectable
// - calibrate first, store per channel offset
// - channel enable raises compensation request
// - host recalibration bit starts next period
// - drift beyond threshold triggers calibration
// - requests latched anytime, run at period start
// - compensation loads low pass filter state with the new result
// - refresh raw, difference, state per channel
// - interrupt pin asserts on proximity
// - interrupt latched or live status
// - three thresholds each raise interrupt
// - mask bit n enables phase n
// - five bit code selects idle time
// - per channel first order low pass filter
`include "cps_consts.vh"

module cps_scan_seq #(
    parameter SLOW_TICKS_PER_MS = `CPS_SLOW_TICKS_PER_MS
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // pins
    input wire slow_tick_clock,
    output wire proximityIrqNOut,
    output wire proximityIrqNOe,
    // configuration
    input wire [3:0] phaseEnableMask,
    input wire dozeEnable,
    input wire [4:0] scanIntervalCode,
    input wire [4:0] dozeIntervalCode,
    input wire [11:0] osrCodes,
    input wire [11:0] avgCodes,
    input wire [11:0] rangeCodes,
    input wire [11:0] alphaCodes,
    input wire recalRequest,
    input wire [15:0] driftThreshold,
    input wire [15:0] proxThresh0,
    input wire [15:0] proxThresh1,
    input wire [15:0] proxThresh2,
    input wire irqLatchMode,
    input wire irqClear,
    // analog front end
    input wire [15:0] adcResult,
    output reg conversionClockRun,
    output reg convTickOut,
    output reg [2:0] fullScaleSel,
    output reg [1:0] activeChannel,
    output reg calActive,
    // status
    output reg anyChannelEnable,
    output reg dozeActive,
    output reg proximityAny,
    // result read
    input wire [1:0] readChannel,
    output wire [15:0] readRaw,
    output wire [15:0] readDiff,
    output wire [1:0] readLevel
);

    localparam ST_IDLE = 2'b00;
    localparam ST_PICK = 2'b01;
    localparam ST_CONV = 2'b10;
    localparam ST_PROC = 2'b11;

    reg rstS1Q, rstS2Q;
    wire rstN = rstS2Q;

    reg [1:0] stateQ;
    reg [2:0] chanQ;
    reg [3:0] scanMaskQ, maskPrevQ;
    reg [10:0] osrCntQ;
    reg [5:0] avgCntQ;
    reg [`CPS_SUM_W-1:0] sumQ;
    reg [`CPS_CONV_DIV_W-1:0] convDivQ;
    reg calRunQ, calPendQ, irqLatchQ, irqOeQ;
    reg [15:0] offsetQ [0:`CPS_NUM_CH-1];
    reg [15:0] lpfQ [0:`CPS_NUM_CH-1];
    reg [1:0] levelQ [0:`CPS_NUM_CH-1];
    integer i;

    wire scanStart;
    wire [`CPS_MEM_W-1:0] memRd;
    reg memWe;
    reg [`CPS_MEM_W-1:0] memWd;

    // lowest enabled channel at or above a start index
    function [2:0] nextChan;
        input [3:0] mask;
        input [2:0] from;
        integer k;
        begin
            nextChan = `CPS_CH_NONE;
            for (k = `CPS_NUM_CH - 1; k >= 0; k = k - 1) begin
                if (mask[k] && (k >= from)) begin
                    nextChan = k[2:0];
                end
            end
        end
    endfunction

    function [2:0] sel3;
        input [11:0] v;
        input [1:0] c;
        begin
            case (c)
                2'h0: sel3 = v[2:0];
                2'h1: sel3 = v[5:3];
                2'h2: sel3 = v[8:6];
                default: sel3 = v[11:9];
            endcase
        end
    endfunction

    function [2:0] clampCode;
        input [2:0] c;
        input [2:0] mx;
        begin
            clampCode = (c > mx) ? mx : c;
        end
    endfunction

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstS1Q <= 1'b0;
            rstS2Q <= 1'b0;
        end else begin
            rstS1Q <= 1'b1;
            rstS2Q <= rstS1Q;
        end
    end

    wire [1:0] ch = chanQ[1:0];
    wire sleepMode = ~|phaseEnableMask;
    wire [2:0] osrCode = clampCode(sel3(osrCodes, ch), `CPS_OSR_CODE_MAX);
    wire [2:0] avgCode = clampCode(sel3(avgCodes, ch), `CPS_AVG_CODE_MAX);
    wire [2:0] alphaCode = clampCode(sel3(alphaCodes, ch), `CPS_ALPHA_CODE_MAX);
    wire [10:0] osrLen = `CPS_OSR_BASE << osrCode;
    wire [5:0] avgLen = 6'h01 << avgCode;
    wire convTick = (convDivQ == `CPS_CONV_DIV - 1);
    wire [`CPS_SUM_W-1:0] avgVal = sumQ >> avgCode;
    wire [15:0] avgRes = avgVal[15:0];

    // filter and difference for the channel being processed
    wire [16:0] lpfDelta = {1'b0, avgRes} - {1'b0, lpfQ[ch]};
    wire [16:0] lpfStep = $signed(lpfDelta) >>> alphaCode;
    wire [16:0] lpfSum = {1'b0, lpfQ[ch]} + lpfStep;
    wire [15:0] lpfNew = lpfSum[15:0];
    wire [16:0] diffWide = {1'b0, lpfNew} - {1'b0, offsetQ[ch]};
    wire diffPos = ~diffWide[16];
    wire [15:0] diffSat = (diffWide[16] != diffWide[15]) ?
        (diffPos ? 16'h7fff : 16'h8000) : diffWide[15:0];
    wire [15:0] diffMag = diffPos ? diffSat : (~diffSat + 16'h0001);
    wire [1:0] newLevel = (diffPos && diffSat >= proxThresh2) ? 2'h3 :
                          (diffPos && diffSat >= proxThresh1) ? 2'h2 :
                          (diffPos && diffSat >= proxThresh0) ? 2'h1 : 2'h0;
    wire procNow = (stateQ == ST_PROC);
    wire driftHit = procNow && !calRunQ && (newLevel == 2'h0) &&
                    (diffMag > driftThreshold);
    wire levelRise = procNow && !calRunQ && (newLevel > levelQ[ch]);
    wire maskRise = |(phaseEnableMask & ~maskPrevQ);
    wire calSet = maskRise | recalRequest | driftHit;
    wire calTake = (stateQ == ST_IDLE) && scanStart && !sleepMode;
    wire proxNow = |{levelQ[3], levelQ[2], levelQ[1], levelQ[0]};
    wire [4:0] periodCode = (dozeEnable && !proxNow) ? dozeIntervalCode : scanIntervalCode;

    cps_scan_timer #(
        .TICKS_PER_MS(SLOW_TICKS_PER_MS)
    ) u_timer (
        .clk(core_clk),
        .rstN(rstN),
        .slowClkPin(slow_tick_clock),
        .run(!sleepMode),
        .ready(stateQ == ST_IDLE),
        .intervalCode(periodCode),
        .scanStart(scanStart)
    );

    cps_result_mem u_mem (
        .clk(core_clk),
        .rstN(rstN),
        .wrEn(memWe),
        .wrAddr(ch),
        .wrData(memWd),
        .rdAddr(readChannel),
        .rdData(memRd)
    );

    assign readRaw = memRd[`CPS_MEM_RAW_LSB +: 16];
    assign readDiff = memRd[`CPS_MEM_DIFF_LSB +: 16];
    assign readLevel = memRd[`CPS_MEM_LVL_LSB +: 2];

    // result word written back each time a channel finishes
    always @* begin
        memWe = procNow;
        if (calRunQ) begin
            memWd = {2'h0, 16'h0000, avgRes};
        end else begin
            memWd = {newLevel, diffSat, avgRes};
        end
    end

    always @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            stateQ <= ST_IDLE;
            chanQ <= `CPS_CH_NONE;
            scanMaskQ <= 4'h0;
            maskPrevQ <= 4'h0;
            osrCntQ <= 11'h000;
            avgCntQ <= 6'h00;
            sumQ <= {`CPS_SUM_W{1'b0}};
            convDivQ <= {`CPS_CONV_DIV_W{1'b0}};
            calRunQ <= 1'b0;
            calPendQ <= 1'b0;
            irqLatchQ <= 1'b0;
            irqOeQ <= 1'b0;
            conversionClockRun <= 1'b0;
            convTickOut <= 1'b0;
            fullScaleSel <= 3'h0;
            activeChannel <= 2'h0;
            calActive <= 1'b0;
            anyChannelEnable <= 1'b0;
            dozeActive <= 1'b0;
            proximityAny <= 1'b0;
            for (i = 0; i < `CPS_NUM_CH; i = i + 1) begin
                offsetQ[i] <= 16'h0000;
                lpfQ[i] <= 16'h0000;
                levelQ[i] <= 2'h0;
            end
        end else begin
            maskPrevQ <= phaseEnableMask;
            // request held until the next period start; a new one wins
            calPendQ <= (calPendQ & ~calTake) | calSet;
            // conversion clock divider only while a scan is in progress
            if (stateQ == ST_IDLE || convTick) begin
                convDivQ <= {`CPS_CONV_DIV_W{1'b0}};
            end else begin
                convDivQ <= convDivQ + 1'b1;
            end
            conversionClockRun <= (stateQ != ST_IDLE) && !sleepMode;
            convTickOut <= convTick && (stateQ == ST_CONV) && !sleepMode;
            anyChannelEnable <= !sleepMode;
            dozeActive <= dozeEnable && !sleepMode && !proxNow;
            proximityAny <= proxNow;
            calActive <= calRunQ && (stateQ != ST_IDLE);
            if (sleepMode) begin
                stateQ <= ST_IDLE;
                chanQ <= `CPS_CH_NONE;
            end else begin
                case (stateQ)
                    ST_IDLE: begin
                        if (scanStart) begin
                            scanMaskQ <= phaseEnableMask;
                            chanQ <= nextChan(phaseEnableMask, 3'h0);
                            calRunQ <= calPendQ;
                            stateQ <= ST_PICK;
                        end
                    end
                    ST_PICK: begin
                        if (chanQ == `CPS_CH_NONE) begin
                            stateQ <= ST_IDLE;
                        end else begin
                            osrCntQ <= 11'h000;
                            avgCntQ <= 6'h00;
                            sumQ <= {`CPS_SUM_W{1'b0}};
                            fullScaleSel <= sel3(rangeCodes, ch);
                            activeChannel <= ch;
                            stateQ <= ST_CONV;
                        end
                    end
                    ST_CONV: begin
                        if (convTick) begin
                            if (osrCntQ == osrLen - 1'b1) begin
                                osrCntQ <= 11'h000;
                                sumQ <= sumQ + {5'h00, adcResult};
                                avgCntQ <= avgCntQ + 1'b1;
                                if (avgCntQ == avgLen - 1'b1) begin
                                    stateQ <= ST_PROC;
                                end
                            end else begin
                                osrCntQ <= osrCntQ + 1'b1;
                            end
                        end
                    end
                    default: begin
                        if (calRunQ) begin
                            offsetQ[ch] <= avgRes;
                            lpfQ[ch] <= avgRes;
                            levelQ[ch] <= 2'h0;
                        end else begin
                            lpfQ[ch] <= lpfNew;
                            levelQ[ch] <= newLevel;
                        end
                        chanQ <= nextChan(scanMaskQ, chanQ + 3'h1);
                        stateQ <= ST_PICK;
                    end
                endcase
            end
            // latched interrupt: a new level sets, host clear loses to a set
            irqLatchQ <= (irqLatchQ & ~irqClear) | levelRise;
            irqOeQ <= irqLatchMode ? ((irqLatchQ & ~irqClear) | levelRise) : proxNow;
        end
    end

    // open drain: drive low while asserted, release otherwise
    assign proximityIrqNOut = 1'b0;
    assign proximityIrqNOe = irqOeQ;

endmodule // cps_scan_seq

// File: sim/cps_afe_model.sv
module cps_afe_model (
    // slow oscillator
    output logic slow_tick_clock,
    // converter side
    input wire logic [1:0] activeChannel,
    input wire logic [15:0] adcBase,
    output logic [15:0] adcResult
);
    timeunit 1ns;
    timeprecision 100ps;

    // free running, never gated by mode
    initial begin
        slow_tick_clock = 1'b0;
        forever #40 slow_tick_clock = ~slow_tick_clock;
    end

    // per channel level so results can be told apart
    assign adcResult = adcBase + {6'h00, activeChannel, 8'h00};
endmodule // cps_afe_model

// File: sim/cps_scan_seq_assertions.sv
module cps_scan_seq_assertions (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // watched ports
    input wire [3:0] phaseEnableMask,
    input wire irqLatchMode,
    input wire irqClear,
    input wire [11:0] rangeCodes,
    input wire proximityIrqNOut,
    input wire proximityIrqNOe,
    input wire conversionClockRun,
    input wire convTickOut,
    input wire [2:0] fullScaleSel,
    input wire [1:0] activeChannel,
    input wire proximityAny
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] lastCh_q;
    logic seen_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // channel of the previous tick within this scan
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastCh_q <= 2'h0;
            seen_q <= 1'b0;
        end else if (!conversionClockRun) begin
            seen_q <= 1'b0;
        end else if (convTickOut) begin
            lastCh_q <= activeChannel;
            seen_q <= 1'b1;
        end
    end

    sequence liveProx;
        (!irqLatchMode && proximityAny)[*3];
    endsequence
    sequence latchHeld;
        irqLatchMode && proximityIrqNOe && !irqClear ##1 irqLatchMode;
    endsequence

    chk_sleep_no_conv: assert property ((phaseEnableMask == 4'h0)[*4] |-> !conversionClockRun)
        else $error("converting with all channels off");
    chk_tick_in_run: assert property (convTickOut |-> conversionClockRun)
        else $error("tick outside a scan");
    chk_tick_gap: assert property (convTickOut |=> !convTickOut[*8])
        else $error("ticks too close");
    chk_tick_channel_on: assert property (convTickOut && phaseEnableMask != 4'h0
        |-> phaseEnableMask[activeChannel])
        else $error("disabled channel converted");
    chk_scan_ascending: assert property (convTickOut && seen_q |-> activeChannel >= lastCh_q)
        else $error("channel order descending");
    chk_range_select: assert property (convTickOut |-> fullScaleSel == rangeCodes[activeChannel*3 +: 3])
        else $error("wrong full scale for channel");
    chk_live_irq: assert property (liveProx |-> proximityIrqNOe)
        else $error("live irq not asserted");
    chk_latch_hold: assert property (latchHeld |-> proximityIrqNOe)
        else $error("latched irq dropped without clear");
    chk_pin_low: assert property (!proximityIrqNOut)
        else $error("open drain data not low");
endmodule // cps_scan_seq_assertions

bind cps_scan_seq cps_scan_seq_assertions chk_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .phaseEnableMask(phaseEnableMask),
    .irqLatchMode(irqLatchMode),
    .irqClear(irqClear),
    .rangeCodes(rangeCodes),
    .proximityIrqNOut(proximityIrqNOut),
    .proximityIrqNOe(proximityIrqNOe),
    .conversionClockRun(conversionClockRun),
    .convTickOut(convTickOut),
    .fullScaleSel(fullScaleSel),
    .activeChannel(activeChannel),
    .proximityAny(proximityAny)
);

// File: sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk, rst_n, dozeEnable, recalRequest, irqLatchMode, irqClear;
    logic [3:0] phaseEnableMask;
    logic [4:0] scanIntervalCode, dozeIntervalCode;
    logic [11:0] osrCodes, avgCodes, rangeCodes, alphaCodes;
    logic [15:0] driftThreshold, proxThresh0, proxThresh1, proxThresh2, adcResult, adcBase;
    logic [1:0] readChannel, activeChannel, readLevel;
    logic slow_tick_clock, proximityIrqNOut, proximityIrqNOe, conversionClockRun, convTickOut;
    logic calActive, anyChannelEnable, dozeActive, proximityAny;
    logic [2:0] fullScaleSel;
    logic [15:0] readRaw, readDiff;
    int n_fail, compares, ticks, gap, r, c;
    bit sawCal;
    logic [3:0] rowMask [5] = '{4'h1, 4'ha, 4'h1, 4'h4, 4'hf};
    logic [2:0] rowOsr [5] = '{3'h0, 3'h1, 3'h7, 3'h0, 3'h2};
    logic [2:0] rowAvg [5] = '{3'h0, 3'h1, 3'h0, 3'h6, 3'h0};
    int rowTicks [5] = '{16, 128, 1024, 512, 256};

    cps_scan_seq #(.SLOW_TICKS_PER_MS(1)) dut_u (.*);
    cps_afe_model afe_u (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (convTickOut) ticks++;
        if (calActive) sawCal = 1'b1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one whole scan, or the rest of the current one
    task automatic waitScan();
        int i;
        for (i = 0; i < 30000 && !conversionClockRun; i++) @(negedge core_clk);
        ticks = 0;
        for (i = 0; i < 50000 && conversionClockRun; i++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
    endtask

    task automatic measureGap();
        int i;
        for (i = 0; i < 30000 && conversionClockRun; i++) @(negedge core_clk);
        for (gap = 0; gap < 30000 && !conversionClockRun; gap++) @(negedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #800000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        {dozeEnable, recalRequest, irqLatchMode, irqClear} = 4'h0;
        phaseEnableMask = 4'h0;
        scanIntervalCode = 5'h01;
        dozeIntervalCode = 5'h05;
        {osrCodes, avgCodes, alphaCodes} = 36'h0;
        rangeCodes = 12'h688;
        driftThreshold = 16'hffff;
        proxThresh0 = 16'h0010;
        proxThresh1 = 16'h0020;
        proxThresh2 = 16'h0030;
        adcBase = 16'h1000;
        readChannel = 2'h0;
        repeat (3) @(negedge core_clk);
        check(proximityIrqNOe, 1'b0);
        check(conversionClockRun, 1'b0);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        for (r = 0; r < 5; r++) begin
            phaseEnableMask = 4'h0;
            repeat (6) @(negedge core_clk);
            check(anyChannelEnable | conversionClockRun, 1'b0);
            osrCodes = {4{rowOsr[r]}};
            avgCodes = {4{rowAvg[r]}};
            sawCal = 1'b0;
            phaseEnableMask = rowMask[r];
            waitScan();
            check(ticks, rowTicks[r]);
            check(sawCal, 1'b1);
            for (c = 0; c < 4; c++) begin
                if (rowMask[r][c]) begin
                    readChannel = c[1:0];
                    repeat (2) @(negedge core_clk);
                    check(readRaw, adcBase + {c[7:0], 8'h00});
                    check(readDiff, 16'h0000);
                end
            end
        end
        // proximity, interrupt modes, doze periods
        phaseEnableMask = 4'h0;
        readChannel = 2'h0;
        {osrCodes, avgCodes} = 24'h0;
        dozeEnable = 1'b1;
        scanIntervalCode = 5'h00;
        repeat (6) @(negedge core_clk);
        phaseEnableMask = 4'h1;
        waitScan();
        adcBase = 16'h1025;
        waitScan();
        waitScan();
        check(readDiff, 16'h0025);
        check(readLevel, 2'h2);
        check(proximityIrqNOe, 1'b1);
        check(dozeActive, 1'b0);
        irqLatchMode = 1'b1;
        adcBase = 16'h1035;
        waitScan();
        waitScan();
        check(readLevel, 2'h3);
        measureGap();
        check(gap < 12, 1'b1);
        sawCal = 1'b0;
        recalRequest = 1'b1;
        @(negedge core_clk);
        recalRequest = 1'b0;
        waitScan();
        waitScan();
        check(sawCal, 1'b1);
        check({readDiff, readLevel, proximityAny}, 19'h0);
        check(dozeActive, 1'b1);
        check(proximityIrqNOe, 1'b1);
        measureGap();
        check(gap > 70, 1'b1);
        irqClear = 1'b1;
        @(negedge core_clk);
        irqClear = 1'b0;
        repeat (2) @(negedge core_clk);
        check(proximityIrqNOe, 1'b0);
        // small drift beyond threshold forces a calibration
        driftThreshold = 16'h0004;
        adcBase = 16'h103a;
        sawCal = 1'b0;
        waitScan();
        waitScan();
        waitScan();
        check(sawCal, 1'b1);
        check(readDiff, 16'h0000);
        // half-weight filter: a step of 0x10 moves the filtered value by 8
        driftThreshold = 16'hffff;
        alphaCodes = 12'h001;
        adcBase = 16'h104a;
        waitScan();
        check(readDiff, 16'h0008);
        // abort mid scan
        for (c = 0; c < 3000 && !conversionClockRun; c++) @(negedge core_clk);
        repeat (30) @(negedge core_clk);
        phaseEnableMask = 4'h0;
        repeat (4) @(negedge core_clk);
        check(conversionClockRun, 1'b0);
        tally_and_finish();
    end
endmodule // testbench
